// *** rtl/xfer_vec_fetch.sv ***
// What this block does
// [R1] Software vector: 0x0400 plus vector times two
// [R2] Read pointer at vector, then fetch descriptor
// [R3] Software aligns descriptors to four bytes
// [R4] Vector entry: 2-byte low RAM address
// [R5] Timer0 A-D: vectors 32-35, group B
// [R6] Timer1/2 A-B: vectors 40,41,44,45
// [R7] DMA ends: vectors 72-75, group E
// [R8] Serial channels 0-2: receive/transmit vectors
// [R9] Software writes zero to reserved enables
// [R10] Descriptor order: modeA, source, modeB, destination, counts
// [R11] Software stores chained descriptors contiguously
// [R12] Descriptors only inside on-chip RAM window
// [R13] Normal mode: one unit per request
// [R14] Count 1 to 65536 supported
// [R15] CPU interrupt after final transfer
// [R16] Count word A is the counter
// [R17] Count word B ignored
// [R18] Enable 1 to controller, 0 to CPU
// [R19] 24-bit pointers increment, decrement or hold
// [R20] End clears source flag or enable
// [R21] Fixed priority, software first
// [R22] External lines and module requests vectors
// [R23] Pointer upper bits all ones
`timescale 1ns/1ns
`include "xfer_vec_regs.svh"
module xfer_vec_fetch (
    // Clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_b,
    // APB slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [11:0]               i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic      [31:0]               o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    // Interrupt source flags
    input  wire logic [`NUM_SRC-1:0]       i_src_req,
    output logic      [`NUM_SRC-1:0]       o_src_clear,
    output logic      [`NUM_SRC-1:0]       o_cpu_route,
    // Internal bus master
    output xfer_vec_pkg::mem_req_type      o_mem,
    input  wire xfer_vec_pkg::mem_rsp_type i_mem,
    // CPU end notice
    output xfer_vec_pkg::cpu_irq_type      o_cpu_irq,
    output logic                           o_busy
);
    // Vector number of a hardware source
    function automatic logic [6:0] vec_num(input logic [5:0] idx);
        logic [6:0] v;
        v = 7'h00;
        // [R22] External interrupt lines
        if (idx < 6'h08) begin
            v = 7'h10 + {1'b0, idx};
        // [R5] Timer 0 requests
        end else if (idx < 6'h0C) begin
            v = 7'h18 + {1'b0, idx};
        // [R6] Timer 1 requests
        end else if (idx < 6'h0E) begin
            v = 7'h1C + {1'b0, idx};
        // [R6] Timer 2 requests
        end else if (idx < 6'h10) begin
            v = 7'h1E + {1'b0, idx};
        // [R7] DMA transfer ends
        end else if (idx < 6'h14) begin
            v = 7'h38 + {1'b0, idx};
        // [R8] Serial channels, two each
        end else if (idx < 6'h1A) begin
            v = 7'h51 + {1'b0, idx[4:1] - 4'hA, 2'h0} + {6'h00, idx[0]};
        // [R22] External module requests
        end else begin
            v = 7'h4E + {1'b0, idx};
        end
        return v;
    endfunction

    // Flat enable bit of a source, groups A,B,C,E,F,G
    function automatic logic [5:0] en_pos(input logic [5:0] idx);
        logic [5:0] p;
        p = 6'h00;
        if (idx < 6'h08) begin
            p = 6'h07 - idx;
        end else if (idx < 6'h0E) begin
            p = 6'h15 - idx;
        end else if (idx < 6'h10) begin
            p = 6'h25 - idx;
        end else if (idx < 6'h18) begin
            p = 6'h2F - idx;
        end else if (idx < 6'h1A) begin
            p = 6'h3F - idx;
        end else begin
            p = 6'h09 - idx;
        end
        return p;
    endfunction

    // Vector address from vector number
    function automatic logic [23:0] vec_addr(input logic [6:0] v);
        // [R4] Two-byte entries, same layout in every mode
        return {`VEC_HIGH_BITS, `VEC_BASE + {8'h00, v, 1'b0}};
    endfunction

    // Pointer update: 0x hold, 10 up, 11 down
    function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] m,
                                         input logic word);
        logic [23:0] d;
        d = word ? 24'h000002 : 24'h000001;
        // [R19] Independent pointer update
        if (!m[1]) begin
            return a;
        end else if (!m[0]) begin
            return a + d;
        end
        return a - d;
    endfunction

    // Core state
    xfer_vec_pkg::state_type   state_reg, state_next;
    xfer_vec_pkg::mem_req_type mem_reg, mem_next;
    xfer_vec_pkg::cpu_irq_type irq_reg, irq_next;
    logic [1:0]                cnt_reg, cnt_next;      // Descriptor word index
    logic                      is_sw_reg, is_sw_next;  // Software activation
    logic [5:0]                idx_reg, idx_next;      // Hardware source index
    logic [23:0]               ptr_reg, ptr_next;      // Descriptor start
    logic [7:0]                mra_reg, mra_next;
    logic [7:0]                mrb_reg, mrb_next;
    logic [23:0]               sar_reg, sar_next;
    logic [23:0]               dar_reg, dar_next;
    logic [15:0]               cra_reg, cra_next;
    logic [15:0]               crb_reg, crb_next;
    logic [15:0]               dat_reg, dat_next;      // Data in flight
    logic [`NUM_SRC-1:0]       clr_reg, clr_next;
    logic                      busy_reg, busy_next;
    // Register state
    logic [7:0]                swvec_reg, swvec_next;
    logic                      swpend_reg, swpend_next;
    logic [47:0]               en_reg, en_next;
    logic [`NUM_SRC-1:0]       route_reg, route_next;
    logic [31:0]               prdata_reg, prdata_next;
    logic                      pready_reg, pready_next;
    logic                      pslverr_reg, pslverr_next;
    // Cross-group strobes
    logic                      pick_sw;
    logic                      end_sw_clr;
    logic                      end_en_clr;
    logic                      final_c;
    logic [`NUM_SRC-1:0]       en_mask;
    logic [`NUM_SRC-1:0]       pend;
    logic [5:0]                pick_idx;
    logic                      pick_hw;

    // Per-source enable mask and pending set
    always_comb begin
        for (int i = 0; i < `NUM_SRC; i++) begin
            en_mask[i] = en_reg[en_pos(6'(i))];
        end
        pend = i_src_req & en_mask;
        pick_idx = 6'h00;
        pick_hw = 1'b0;
        // [R21] Lowest index wins among hardware sources
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick_idx = 6'(i);
                pick_hw = 1'b1;
            end
        end
    end

    // Core sequencer next values
    always_comb begin
        state_next = state_reg;
        mem_next   = mem_reg;
        irq_next   = '0;
        clr_next   = '0;
        cnt_next   = cnt_reg;
        is_sw_next = is_sw_reg;
        idx_next   = idx_reg;
        ptr_next   = ptr_reg;
        mra_next   = mra_reg;
        mrb_next   = mrb_reg;
        sar_next   = sar_reg;
        dar_next   = dar_reg;
        cra_next   = cra_reg;
        crb_next   = crb_reg;
        dat_next   = dat_reg;
        pick_sw    = 1'b0;
        end_sw_clr = 1'b0;
        end_en_clr = 1'b0;
        // [R15] Final when count A runs out or per-transfer irq set
        final_c    = (cra_reg == 16'h0000) || mrb_reg[`MRB_PER_TRANSFER_IRQ_SELECT_BIT];
        case (state_reg)
            // Pick a source and read its vector
            xfer_vec_pkg::ST_IDLE: begin
                // [R21] Software activation first
                if (swpend_reg) begin
                    pick_sw = 1'b1;
                    is_sw_next = 1'b1;
                    // [R1] Software vector address
                    mem_next = '{1'b1, 1'b0, 1'b1,
                                 vec_addr(swvec_reg[`SWVEC_VEC_MSB:0]), 32'h0};
                    state_next = xfer_vec_pkg::ST_VEC;
                end else if (pick_hw) begin
                    is_sw_next = 1'b0;
                    idx_next = pick_idx;
                    mem_next = '{1'b1, 1'b0, 1'b1, vec_addr(vec_num(pick_idx)), 32'h0};
                    state_next = xfer_vec_pkg::ST_VEC;
                end
            end
            // Vector entry returns the descriptor pointer
            xfer_vec_pkg::ST_VEC: begin
                if (i_mem.ack) begin
                    // [R23] Upper pointer bits all ones
                    ptr_next = {`RAM_HIGH_BITS, i_mem.rdata[15:0]};
                    // [R2] Fetch descriptor from the pointer
                    mem_next = '{1'b1, 1'b0, 1'b0,
                                 {`RAM_HIGH_BITS, i_mem.rdata[15:0]}, 32'h0};
                    cnt_next = 2'h0;
                    state_next = xfer_vec_pkg::ST_DESC;
                end
            end
            // Three long words of descriptor
            xfer_vec_pkg::ST_DESC: begin
                if (i_mem.ack) begin
                    // [R10] Mode A with source, mode B with destination, counts
                    if (cnt_reg == 2'h0) begin
                        {mra_next, sar_next} = i_mem.rdata;
                    end else if (cnt_reg == 2'h1) begin
                        {mrb_next, dar_next} = i_mem.rdata;
                    end else begin
                        {cra_next, crb_next} = i_mem.rdata;
                    end
                    if (cnt_reg == `DESC_LAST) begin
                        mem_next = '{1'b1, 1'b0, mra_reg[`MRA_SIZE_BIT], sar_reg, 32'h0};
                        state_next = xfer_vec_pkg::ST_RD;
                    end else begin
                        cnt_next = cnt_reg + 2'h1;
                        // [R3] Stride assumes four-byte aligned start
                        mem_next.addr = mem_reg.addr + `DESC_STRIDE;
                    end
                end
            end
            // [R13] One byte or word read, then written
            xfer_vec_pkg::ST_RD: begin
                if (i_mem.ack) begin
                    dat_next = i_mem.rdata[15:0];
                    mem_next = '{1'b1, 1'b1, mra_reg[`MRA_SIZE_BIT], dar_reg,
                                 {16'h0000, i_mem.rdata[15:0]}};
                    state_next = xfer_vec_pkg::ST_WR;
                end
            end
            // Write done: update pointers and count
            xfer_vec_pkg::ST_WR: begin
                if (i_mem.ack) begin
                    sar_next = step(sar_reg, mra_reg[`MRA_SRC_MSB -: 2], mra_reg[0]);
                    dar_next = step(dar_reg, mra_reg[`MRA_DST_MSB -: 2], mra_reg[0]);
                    // [R16] Count A counts; [R14] zero wraps for 65536
                    cra_next = cra_reg - 16'h0001;
                    mem_next = '{1'b1, 1'b1, 1'b0, ptr_reg, {mra_reg, sar_next}};
                    cnt_next = 2'h0;
                    state_next = xfer_vec_pkg::ST_WB;
                end
            end
            // Write updated descriptor back
            xfer_vec_pkg::ST_WB: begin
                if (i_mem.ack) begin
                    if (cnt_reg == `DESC_LAST) begin
                        mem_next.req = 1'b0;
                        state_next = xfer_vec_pkg::ST_END;
                    end else begin
                        cnt_next = cnt_reg + 2'h1;
                        mem_next.addr = mem_reg.addr + `DESC_STRIDE;
                        // [R17] Count B only carried back unchanged
                        mem_next.wdata = (cnt_reg == 2'h0) ? {mrb_reg, dar_reg}
                                                           : {cra_reg, crb_reg};
                    end
                end
            end
            // [R20] Not final: clear flag; final: clear hardware enable, notify CPU
            xfer_vec_pkg::ST_END: begin
                state_next = xfer_vec_pkg::ST_SETTLE;
                if (is_sw_reg) begin
                    end_sw_clr = !final_c;
                end else if (!final_c) begin
                    clr_next[idx_reg] = 1'b1;
                end else begin
                    end_en_clr = 1'b1;
                end
                // [R15] End notice to the CPU
                irq_next = '{final_c, is_sw_reg,
                             is_sw_reg ? swvec_reg[`SWVEC_VEC_MSB:0] : vec_num(idx_reg)};
            end
            // Lets a cleared source flag fall before the next pick
            default: begin
                state_next = xfer_vec_pkg::ST_IDLE;
            end
        endcase
        busy_next = (state_next != xfer_vec_pkg::ST_IDLE);
    end

    // Core sequencer registers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= xfer_vec_pkg::ST_IDLE;
            mem_reg   <= '0;
            irq_reg   <= '0;
            clr_reg   <= '0;
            cnt_reg   <= 2'h0;
            is_sw_reg <= 1'b0;
            idx_reg   <= 6'h00;
            ptr_reg   <= 24'h000000;
            mra_reg   <= 8'h00;
            mrb_reg   <= 8'h00;
            sar_reg   <= 24'h000000;
            dar_reg   <= 24'h000000;
            cra_reg   <= 16'h0000;
            crb_reg   <= 16'h0000;
            dat_reg   <= 16'h0000;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            mem_reg   <= mem_next;
            irq_reg   <= irq_next;
            clr_reg   <= clr_next;
            cnt_reg   <= cnt_next;
            is_sw_reg <= is_sw_next;
            idx_reg   <= idx_next;
            ptr_reg   <= ptr_next;
            mra_reg   <= mra_next;
            mrb_reg   <= mrb_next;
            sar_reg   <= sar_next;
            dar_reg   <= dar_next;
            cra_reg   <= cra_next;
            crb_reg   <= crb_next;
            dat_reg   <= dat_next;
            busy_reg  <= busy_next;
        end
    end

    // APB registers and routing next values
    always_comb begin
        logic acc;
        logic [11:0] a;
        acc          = i_psel && i_penable;
        a            = i_paddr;
        swvec_next   = swvec_reg;
        en_next      = en_reg;
        swpend_next  = swpend_reg && !pick_sw;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = acc && !pready_reg;
        // [R18] Disabled flags go to the CPU
        route_next   = i_src_req & ~en_mask;
        // Hardware clears first, so a same-cycle write wins
        if (end_sw_clr) begin
            swvec_next[`SWVEC_FLAG_BIT] = 1'b0;
        end
        if (end_en_clr) begin
            en_next[en_pos(idx_reg)] = 1'b0;
        end
        // Read data and error prepared one cycle ahead of pready
        if (pready_next) begin
            prdata_next = 32'h0;
            if (a == `OFS_SWVEC) begin
                prdata_next = {24'h0, swvec_next};
            end else if (a >= `OFS_EN_A && a <= `OFS_EN_G) begin
                prdata_next = {24'h0, en_reg[{a[4:2] - 3'h1, 3'h0} +: 8]};
            end else if (a == `OFS_STATUS) begin
                prdata_next = {18'h0, idx_reg, 6'h0, swpend_reg, o_busy};
            end else begin
                pslverr_next = 1'b1;
            end
        end
        // Write commits at the edge that sees pready
        if (acc && pready_reg && i_pwrite) begin
            if (a == `OFS_SWVEC) begin
                swvec_next  = i_pwdata[7:0];
                swpend_next = i_pwdata[`SWVEC_FLAG_BIT];
            end else if (a >= `OFS_EN_A && a <= `OFS_EN_G) begin
                en_next[{a[4:2] - 3'h1, 3'h0} +: 8] = i_pwdata[7:0];
            end
        end
    end

    // APB registers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            swvec_reg   <= `RST_SWVEC;
            swpend_reg  <= 1'b0;
            en_reg      <= `RST_EN;
            route_reg   <= '0;
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            swvec_reg   <= swvec_next;
            swpend_reg  <= swpend_next;
            en_reg      <= en_next;
            route_reg   <= route_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_prdata    = prdata_reg;
    assign o_pready    = pready_reg;
    assign o_pslverr   = pslverr_reg;
    assign o_mem       = mem_reg;
    assign o_cpu_irq   = irq_reg;
    assign o_src_clear = clr_reg;
    assign o_cpu_route = route_reg;
    assign o_busy      = busy_reg;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    // Vector read, then pointer read
    sequence s_vec_done;
        state_reg == xfer_vec_pkg::ST_VEC && i_mem.ack;
    endsequence
    sequence s_ptr_issued;
        mem_reg.req && !mem_reg.we && mem_reg.addr[23:16] == `RAM_HIGH_BITS;
    endsequence

    AST_SW_VEC: assert property (pick_sw |=> mem_reg.addr == // [R1]
        {8'h00, 16'h0400 + {8'h00, $past(swvec_reg[6:0]), 1'b0}})
        else $error("software vector address wrong");
    AST_PTR: assert property (s_vec_done |=> s_ptr_issued ##0 // [R23]
        mem_reg.addr[15:0] == $past(i_mem.rdata[15:0]))
        else $error("descriptor pointer wrong");
    AST_DESC_STEP: assert property (state_reg == xfer_vec_pkg::ST_DESC && i_mem.ack // [R10]
        && cnt_reg != 2'h2 |=> mem_reg.addr == $past(mem_reg.addr) + 24'h4)
        else $error("descriptor word address wrong");
    AST_ONE_UNIT: assert property (state_reg == xfer_vec_pkg::ST_RD && i_mem.ack // [R13]
        |=> mem_reg.we && mem_reg.addr == dar_reg && state_reg == xfer_vec_pkg::ST_WR)
        else $error("data write not issued");
    AST_COUNT: assert property (state_reg == xfer_vec_pkg::ST_WR && i_mem.ack // [R16]
        |=> cra_reg == $past(cra_reg) - 16'h1 && crb_reg == $past(crb_reg))
        else $error("count update wrong");
    AST_HOLD: assert property (state_reg == xfer_vec_pkg::ST_WR && i_mem.ack // [R19]
        && !mra_reg[7] |=> sar_reg == $past(sar_reg))
        else $error("held source pointer moved");
    AST_END_IRQ: assert property (state_reg == xfer_vec_pkg::ST_END && final_c // [R15]
        |=> o_cpu_irq.irq ##1 !o_cpu_irq.irq)
        else $error("end interrupt missing");
    AST_CLEAR: assert property (state_reg == xfer_vec_pkg::ST_END && !is_sw_reg // [R20]
        && !final_c |=> o_src_clear == $past(`NUM_SRC'(1) << idx_reg))
        else $error("source flag clear wrong");
    AST_ROUTE: assert property (##1 o_cpu_route == // [R18]
        ($past(i_src_req) & ~$past(en_mask)))
        else $error("routing wrong");
    AST_PRIO: assert property (state_reg == xfer_vec_pkg::ST_IDLE && swpend_reg // [R21]
        |=> is_sw_reg && state_reg == xfer_vec_pkg::ST_VEC)
        else $error("software not served first");
endmodule

// *** rtl/xfer_vec_regs.svh ***
`ifndef XFER_VEC_REGS_SVH
`define XFER_VEC_REGS_SVH
// Register byte offsets on the APB
`define OFS_SWVEC         12'h000
`define OFS_EN_A          12'h004
`define OFS_EN_B          12'h008
`define OFS_EN_C          12'h00C
`define OFS_EN_E          12'h010
`define OFS_EN_F          12'h014
`define OFS_EN_G          12'h018
`define OFS_STATUS        12'h01C
// Software vector register fields
`define SWVEC_FLAG_BIT    7
`define SWVEC_VEC_MSB     6
// Reset values
`define RST_SWVEC         8'h00
`define RST_EN            48'h0
// Vector table and descriptor window
`define VEC_BASE          16'h0400
`define RAM_HIGH_BITS     8'hFF
`define VEC_HIGH_BITS     8'h00
`define RAM_WIN_LO        24'hFFEBC0
`define RAM_WIN_HI        24'hFFEFBF
`define DESC_STRIDE       24'h000004
`define DESC_LAST         2'h2
// Mode word fields
`define MRA_SRC_MSB       7
`define MRA_DST_MSB       5
`define MRA_SIZE_BIT      0
`define MRB_PER_TRANSFER_IRQ_SELECT_BIT     6
// Source count
`define NUM_SRC           34
`endif

// *** rtl/xfer_vec_pkg.sv ***
package xfer_vec_pkg;
    // Core sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_VEC, ST_DESC, ST_RD, ST_WR, ST_WB, ST_END, ST_SETTLE
    } state_type;
    // Request toward the internal bus
    typedef struct packed {
        logic        req;
        logic        we;
        logic        word;
        logic [23:0] addr;
        logic [31:0] wdata;
    } mem_req_type;
    // Answer from the internal bus
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } mem_rsp_type;
    // End notice to the CPU
    typedef struct packed {
        logic       irq;
        logic       from_sw;
        logic [6:0] vector;
    } cpu_irq_type;
endpackage

// *** test/xfer_mem_model.sv ***
`timescale 1ns/1ns
// Internal bus and RAM seen by the fetch engine
module xfer_mem_model (
    // Clock, reset and stall length
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_b,
    input  wire logic [3:0]                i_wait,
    // Bus request and answer
    input  wire xfer_vec_pkg::mem_req_type i_mem,
    output xfer_vec_pkg::mem_rsp_type      o_mem
);
    logic [31:0] mem [logic [23:0]];  // Sparse RAM, one word per address
    logic [23:0] log [$];             // Addresses in the order served
    logic [3:0]  cnt;                 // Stall cycles spent so far
    // Answer after the stall; read data toggles while no answer stands
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mem <= '0;
            cnt   <= 4'h0;
        end else if (i_mem.req && !o_mem.ack && cnt >= i_wait) begin
            o_mem.ack   <= 1'b1;
            o_mem.rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : 32'hDEADBEEF;
            if (i_mem.we) mem[i_mem.addr] = i_mem.wdata;
            log.push_back(i_mem.addr);
            cnt <= 4'h0;
        end else begin
            o_mem.ack   <= 1'b0;
            o_mem.rdata <= ~o_mem.rdata;
            cnt         <= i_mem.req ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// *** test/test_transfer_vector_fetch_normal_mode.sv ***
`timescale 1ns/1ns
`include "xfer_vec_regs.svh"
module test_transfer_vector_fetch_normal_mode;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, busy;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [33:0] src_req = 34'h0, src_clear, cpu_route, clr_last = 34'h0;
    logic [3:0]  wc = 4'h0;
    xfer_vec_pkg::mem_req_type mreq;
    xfer_vec_pkg::mem_rsp_type mrsp;
    xfer_vec_pkg::cpu_irq_type irq, irq_last = '0;
    int          bad_count = 0, checked = 0, irq_n = 0, cyc = 0, n0;
    // Source table: flag index, enable group, enable bit, vector address
    int          idx_t [10] = '{8, 11, 13, 14, 16, 19, 23, 25, 0, 33};
    int          bit_t [10] = '{5, 2, 0, 7, 7, 4, 0, 6, 7, 0};
    logic [11:0] off_t [10] = '{`OFS_EN_B, `OFS_EN_B, `OFS_EN_B, `OFS_EN_C, `OFS_EN_E,
                                `OFS_EN_E, `OFS_EN_E, `OFS_EN_F, `OFS_EN_A, `OFS_EN_G};
    logic [15:0] va_t [10] = '{16'h0440, 16'h0446, 16'h0452, 16'h0458, 16'h0490,
                               16'h0496, 16'h04AC, 16'h04B4, 16'h0420, 16'h04DE};
    xfer_vec_fetch xfer_vec_fetch_i (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_src_req(src_req),
        .o_src_clear(src_clear), .o_cpu_route(cpu_route), .o_mem(mreq), .i_mem(mrsp),
        .o_cpu_irq(irq), .o_busy(busy));
    xfer_mem_model xfer_mem_model_i (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wait(wc), .i_mem(mreq), .o_mem(mrsp));
    always #4 i_sys_clk = ~i_sys_clk;
    // Watch end notices, answer flag clears, cut a hang short
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (irq.irq === 1'b1) begin
            irq_n    <= irq_n + 1;
            irq_last <= irq;
        end
        if (|src_clear) begin
            clr_last <= src_clear;
            src_req  <= src_req & ~src_clear;
        end
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; waits for pready without assuming a latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge i_sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Wait for one activation to start and finish
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin @(posedge i_sys_clk); n++; end
        while (busy !== 1'b0 && n < 600) begin @(posedge i_sys_clk); n++; end
        @(posedge i_sys_clk);
    endtask
    function logic [23:0] nxt(input logic [1:0] m, input logic [23:0] p, input logic w);
        nxt = (m == 2'h2) ? p + (w ? 24'h2 : 24'h1) : (m == 2'h3) ? p - (w ? 24'h2 : 24'h1) : p;
    endfunction
    // Descriptor aligned, inside the RAM window, words contiguous
    // placement
    task set_desc(input logic [7:0] mode_word_a, input logic [15:0] count_word_a);
        xfer_mem_model_i.mem[24'hFFEC00] = {mode_word_a, 24'hFFED00};
        xfer_mem_model_i.mem[24'hFFEC04] = {8'h00, 24'hFFED10};
        xfer_mem_model_i.mem[24'hFFEC08] = {count_word_a, 16'h1234};
        xfer_mem_model_i.mem[24'hFFED00] = 32'h0000A55A;
        xfer_mem_model_i.log.delete();
        clr_last <= '0;
        n0 = irq_n;
    endtask
    task check_run(input logic [15:0] va, input logic [7:0] mode_word_a, input logic [15:0] count_word_a);
        logic [23:0] e [9];
        e = '{{8'h00, va}, 24'hFFEC00, 24'hFFEC04, 24'hFFEC08, 24'hFFED00, 24'hFFED10,
              24'hFFEC00, 24'hFFEC04, 24'hFFEC08};
        for (int k = 0; k < 9; k++) chk({8'h00, xfer_mem_model_i.log[k]}, {8'h00, e[k]});
        chk(xfer_mem_model_i.mem[24'hFFEC00], {mode_word_a, nxt(mode_word_a[7:6], 24'hFFED00, mode_word_a[0])});
        chk(xfer_mem_model_i.mem[24'hFFEC04], {8'h00, nxt(mode_word_a[5:4], 24'hFFED10, mode_word_a[0])});
        chk(xfer_mem_model_i.mem[24'hFFEC08], {count_word_a - 16'h0001, 16'h1234});
        chk(xfer_mem_model_i.mem[24'hFFED10] & (mode_word_a[0] ? 32'hFFFF : 32'hFF),
            mode_word_a[0] ? 32'hA55A : 32'h5A);
        chk(32'(irq_n - n0), {31'h0, count_word_a == 16'h0001});
    endtask
    task run_sw(input logic [7:0] mode_word_a, input logic [15:0] count_word_a);
        set_desc(mode_word_a, count_word_a);
        apb(1'b1, `OFS_SWVEC, 32'h90, rd);
        wait_idle();
        check_run(16'h0420, mode_word_a, count_word_a);
        apb(1'b0, `OFS_SWVEC, 32'h0, rd);
        chk(rd, (count_word_a == 16'h0001) ? 32'h90 : 32'h10);
        if (count_word_a == 16'h0001) chk({24'h0, irq_last.from_sw, irq_last.vector}, 32'h90);
    endtask
    // Enable writes touch mapped bits only
    // reserved zero
    task run_hw(input int k, input logic [15:0] count_word_a);
        set_desc(8'hA0, count_word_a);
        apb(1'b1, off_t[k], 32'h1 << bit_t[k], rd);
        src_req[idx_t[k]] <= 1'b1;
        wait_idle();
        check_run(va_t[k], 8'hA0, count_word_a);
        apb(1'b0, off_t[k], 32'h0, rd);
        chk(rd, (count_word_a == 16'h0001) ? 32'h0 : 32'h1 << bit_t[k]);
        chk(32'(((count_word_a == 16'h0001) ? cpu_route : clr_last) >> idx_t[k]), 32'h1);
        if (count_word_a == 16'h0001) chk({25'h0, irq_last.vector}, {25'h0, va_t[k][7:1]});
        src_req[idx_t[k]] <= 1'b0;
        apb(1'b1, off_t[k], 32'h0, rd);
    endtask
    initial begin
        for (int a = 0; a < 128; a++) xfer_mem_model_i.mem[24'h000400 + 24'(2 * a)] = 32'hEC00;
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        apb(1'b0, `OFS_SWVEC, 32'h0, rd);
        chk(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0, rd);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, `OFS_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        run_sw(8'hA0, 16'h0002);
        wc <= 4'h3;
        run_sw(8'hF1, 16'h0000);
        wc <= 4'h0;
        run_sw(8'h20, 16'h0001);
        apb(1'b1, `OFS_SWVEC, 32'h0, rd);
        for (int k = 0; k < 10; k++) run_hw(k, 16'h0002);
        run_hw(9, 16'h0001);
        wrap_up();
    end
endmodule
